// *** hdl/srb_defines.svh ***
// constants for the special function register bank
`ifndef SRB_DEFINES_SVH
`define SRB_DEFINES_SVH

`define SRB_NUM_REGS 23

// byte addresses in the special function space
`define SRB_A_DATA_POINTER_PAIR_LO 8'h82
`define SRB_A_DATA_POINTER_PAIR_HI 8'h83
`define SRB_A_CLK_DIV 8'h95
`define SRB_A_CONV_CTL 8'h97
`define SRB_A_MODE_B 8'hA1
`define SRB_A_AUX_FN 8'hA2
`define SRB_A_IN_SEL 8'hA3
`define SRB_A_CMP_ONE 8'hAC
`define SRB_A_CMP_TWO 8'hAD
`define SRB_A_LO_BOUND 8'hBC
`define SRB_A_BAUD_CTL 8'hBD
`define SRB_A_BAUD_LO 8'hBE
`define SRB_A_BAUD_HI 8'hBF
`define SRB_A_MODE_A 8'hC0
`define SRB_A_HI_BOUND 8'hC4
`define SRB_A_RESULT_0 8'hD5
`define SRB_A_RESULT_1 8'hD6
`define SRB_A_RESULT_2 8'hD7
`define SRB_A_ACCUM 8'hE0
`define SRB_A_FLASH_LO 8'hE6
`define SRB_A_FLASH_HI 8'hE7
`define SRB_A_MULT_OP 8'hF0
`define SRB_A_RESULT_3 8'hF5

// bank slot of each register
`define SRB_I_DATA_POINTER_PAIR_LO 5'h0_0
`define SRB_I_DATA_POINTER_PAIR_HI 5'h0_1
`define SRB_I_CLK_DIV 5'h0_2
`define SRB_I_CONV_CTL 5'h0_3
`define SRB_I_MODE_B 5'h0_4
`define SRB_I_AUX_FN 5'h0_5
`define SRB_I_IN_SEL 5'h0_6
`define SRB_I_CMP_ONE 5'h0_7
`define SRB_I_CMP_TWO 5'h0_8
`define SRB_I_LO_BOUND 5'h0_9
`define SRB_I_BAUD_CTL 5'h0_A
`define SRB_I_BAUD_LO 5'h0_B
`define SRB_I_BAUD_HI 5'h0_C
`define SRB_I_MODE_A 5'h0_D
`define SRB_I_HI_BOUND 5'h0_E
`define SRB_I_RESULT_0 5'h0_F
`define SRB_I_RESULT_1 5'h1_0
`define SRB_I_RESULT_2 5'h1_1
`define SRB_I_ACCUM 5'h1_2
`define SRB_I_FLASH_LO 5'h1_3
`define SRB_I_FLASH_HI 5'h1_4
`define SRB_I_MULT_OP 5'h1_5
`define SRB_I_RESULT_3 5'h1_6

// reset values
`define SRB_RST_ZERO 8'h00
`define SRB_RST_HI_BOUND 8'hFF

// software writable bits of the mixed registers
`define SRB_WM_FULL 8'hFF
`define SRB_WM_IN_SEL 8'hF0
`define SRB_WM_MODE_A 8'hF0
`define SRB_WM_MODE_B 8'hEA
`define SRB_WM_AUX_FN 8'hF1
`define SRB_WM_BAUD_CTL 8'h03
`define SRB_WM_CMP 8'h3D

// field positions
`define SRB_B_CONV_DONE 3
`define SRB_B_SOFT_RESET 3
`define SRB_B_CMP_OUT 1
`define SRB_B_CMP_CHANGE 0

// bit address bases of the bit addressable registers
`define SRB_BIT_BASE_ACCUM 5'h1_C
`define SRB_BIT_BASE_MULT 5'h1_E

`endif

// *** hdl/srb_pkg.sv ***
// types for the special function register bank
package srb_pkg;
  typedef logic [7:0] srb_byte_t;
  typedef logic [4:0] srb_slot_t;
  typedef struct packed {
    logic hit;
    srb_slot_t slot;
  } srb_decode_t;
endpackage

// *** hdl/srb_bank.sv ***
// special function register bank reached by the core
`timescale 1ns/1ps

`include "srb_defines.svh"

module srb_bank
  import srb_pkg::*;
(
  // clock, reset, enable
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  input wire logic CE_IN,
  // byte access from the core
  input wire logic [7:0] ADDR_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic [7:0] WDATA_IN,
  output logic [7:0] RDATA_OUT,
  // bit access from the core
  input wire logic [7:0] BIT_ADDR_IN,
  input wire logic BIT_WR_IN,
  input wire logic BIT_VAL_IN,
  input wire logic BIT_RD_IN,
  output logic BIT_DATA_OUT,
  // peripheral status inputs
  input wire logic CONV_DONE_SET_IN,
  input wire logic [3:0] RESULT_LOAD_IN,
  input wire logic [7:0] RESULT_DATA_IN,
  input wire logic [1:0] CMP_LEVEL_IN,
  input wire logic [1:0] CMP_CHANGE_SET_IN,
  // register contents toward the peripherals
  output logic [15:0] DATA_POINTER_OUT,
  output logic [7:0] CLOCK_DIVIDER_OUT,
  output logic [7:0] CONV_CONTROL_OUT,
  output logic [7:0] CONV_MODE_A_OUT,
  output logic [7:0] CONV_MODE_B_OUT,
  output logic [7:0] CONV_INPUT_SEL_OUT,
  output logic [7:0] LOWER_BOUND_OUT,
  output logic [7:0] UPPER_BOUND_OUT,
  output logic [7:0] AUX_FUNCTION_OUT,
  output logic SOFT_RESET_OUT,
  output logic [7:0] CMP_ONE_CONTROL_OUT,
  output logic [7:0] CMP_TWO_CONTROL_OUT,
  output logic [1:0] BAUD_CONTROL_OUT,
  output logic [15:0] BAUD_DIVISOR_OUT,
  output logic [15:0] FLASH_ADDRESS_OUT,
  output logic [7:0] ACCUMULATOR_OUT,
  output logic [7:0] MULT_OPERAND_OUT
);

  srb_byte_t bank [`SRB_NUM_REGS];
  srb_byte_t next_bank [`SRB_NUM_REGS];
  srb_decode_t wr_dec;
  srb_decode_t rd_dec;
  srb_decode_t bit_dec;
  logic soft_reset;
  logic byte_wr;
  logic bit_wr;

  // map a byte address to its slot; unknown addresses miss
  function automatic srb_decode_t decode(input srb_byte_t addr);
    srb_decode_t d;
    d.hit = 1'b1;
    case (addr)
      `SRB_A_DATA_POINTER_PAIR_LO: begin
        d.slot = `SRB_I_DATA_POINTER_PAIR_LO;
      end
      `SRB_A_DATA_POINTER_PAIR_HI: begin
        d.slot = `SRB_I_DATA_POINTER_PAIR_HI;
      end
      `SRB_A_CLK_DIV: begin
        d.slot = `SRB_I_CLK_DIV;
      end
      `SRB_A_CONV_CTL: begin
        d.slot = `SRB_I_CONV_CTL;
      end
      `SRB_A_MODE_B: begin
        d.slot = `SRB_I_MODE_B;
      end
      `SRB_A_AUX_FN: begin
        d.slot = `SRB_I_AUX_FN;
      end
      `SRB_A_IN_SEL: begin
        d.slot = `SRB_I_IN_SEL;
      end
      `SRB_A_CMP_ONE: begin
        d.slot = `SRB_I_CMP_ONE;
      end
      `SRB_A_CMP_TWO: begin
        d.slot = `SRB_I_CMP_TWO;
      end
      `SRB_A_LO_BOUND: begin
        d.slot = `SRB_I_LO_BOUND;
      end
      `SRB_A_BAUD_CTL: begin
        d.slot = `SRB_I_BAUD_CTL;
      end
      `SRB_A_BAUD_LO: begin
        d.slot = `SRB_I_BAUD_LO;
      end
      `SRB_A_BAUD_HI: begin
        d.slot = `SRB_I_BAUD_HI;
      end
      `SRB_A_MODE_A: begin
        d.slot = `SRB_I_MODE_A;
      end
      `SRB_A_HI_BOUND: begin
        d.slot = `SRB_I_HI_BOUND;
      end
      `SRB_A_RESULT_0: begin
        d.slot = `SRB_I_RESULT_0;
      end
      `SRB_A_RESULT_1: begin
        d.slot = `SRB_I_RESULT_1;
      end
      `SRB_A_RESULT_2: begin
        d.slot = `SRB_I_RESULT_2;
      end
      `SRB_A_ACCUM: begin
        d.slot = `SRB_I_ACCUM;
      end
      `SRB_A_FLASH_LO: begin
        d.slot = `SRB_I_FLASH_LO;
      end
      `SRB_A_FLASH_HI: begin
        d.slot = `SRB_I_FLASH_HI;
      end
      `SRB_A_MULT_OP: begin
        d.slot = `SRB_I_MULT_OP;
      end
      `SRB_A_RESULT_3: begin
        d.slot = `SRB_I_RESULT_3;
      end
      default: begin
        d.hit = 1'b0;
        d.slot = `SRB_I_DATA_POINTER_PAIR_LO;
      end
    endcase
    return d;
  endfunction

  // bits that software may change; the rest keep their value
  function automatic srb_byte_t write_mask(input int slot);
    case (slot)
      `SRB_I_IN_SEL: begin
        return `SRB_WM_IN_SEL;
      end
      `SRB_I_MODE_A: begin
        return `SRB_WM_MODE_A;
      end
      `SRB_I_MODE_B: begin
        return `SRB_WM_MODE_B;
      end
      `SRB_I_AUX_FN: begin
        return `SRB_WM_AUX_FN;
      end
      `SRB_I_BAUD_CTL: begin
        return `SRB_WM_BAUD_CTL;
      end
      `SRB_I_CMP_ONE: begin
        return `SRB_WM_CMP;
      end
      `SRB_I_CMP_TWO: begin
        return `SRB_WM_CMP;
      end
      default: begin
        return `SRB_WM_FULL;
      end
    endcase
  endfunction

  function automatic srb_byte_t reset_value(input int slot);
    case (slot)
      `SRB_I_HI_BOUND: begin
        return `SRB_RST_HI_BOUND;
      end
      default: begin
        return `SRB_RST_ZERO;
      end
    endcase
  endfunction

  // bit address to slot: bits 7..3 pick the register
  function automatic srb_decode_t bit_decode(input srb_byte_t baddr);
    srb_decode_t d;
    d.hit = 1'b1;
    case (baddr[7:3])
      `SRB_BIT_BASE_ACCUM: begin
        d.slot = `SRB_I_ACCUM;
      end
      `SRB_BIT_BASE_MULT: begin
        d.slot = `SRB_I_MULT_OP;
      end
      default: begin
        d.hit = 1'b0;
        d.slot = `SRB_I_DATA_POINTER_PAIR_LO;
      end
    endcase
    return d;
  endfunction

  // what a byte read returns; a miss answers zero
  function automatic srb_byte_t read_view(input srb_decode_t dec,
                                          input srb_byte_t value);
    if (!dec.hit) begin
      return 8'h00;
    end
    return value;
  endfunction

  // result register of each converter channel
  function automatic srb_slot_t result_slot(input int chan);
    case (chan)
      0: begin
        return `SRB_I_RESULT_0;
      end
      1: begin
        return `SRB_I_RESULT_1;
      end
      2: begin
        return `SRB_I_RESULT_2;
      end
      default: begin
        return `SRB_I_RESULT_3;
      end
    endcase
  endfunction

  assign wr_dec = decode(ADDR_IN);
  assign rd_dec = decode(ADDR_IN);
  assign bit_dec = bit_decode(BIT_ADDR_IN);
  assign byte_wr = WR_IN && wr_dec.hit;
  assign bit_wr = BIT_WR_IN && bit_dec.hit;

  // next contents of every register
  always_comb begin
    for (int i = 0; i < `SRB_NUM_REGS; i++) begin
      next_bank[i] = bank[i];
      if (byte_wr && int'(wr_dec.slot) == i) begin
        next_bank[i] = (bank[i] & ~write_mask(i))
                     | (WDATA_IN & write_mask(i));
      end
      if (bit_wr && int'(bit_dec.slot) == i) begin
        next_bank[i][BIT_ADDR_IN[2:0]] = BIT_VAL_IN;
      end
    end
    // converter results loaded by the converter, one per channel
    for (int c = 0; c < 4; c++) begin
      if (RESULT_LOAD_IN[c]) begin
        next_bank[result_slot(c)] = RESULT_DATA_IN;
      end
    end
    // hardware set wins over a software clear in the same cycle
    if (CONV_DONE_SET_IN) begin
      next_bank[`SRB_I_CONV_CTL][`SRB_B_CONV_DONE] = 1'b1;
    end
    next_bank[`SRB_I_CMP_ONE][`SRB_B_CMP_OUT] = CMP_LEVEL_IN[0];
    next_bank[`SRB_I_CMP_TWO][`SRB_B_CMP_OUT] = CMP_LEVEL_IN[1];
    if (CMP_CHANGE_SET_IN[0]) begin
      next_bank[`SRB_I_CMP_ONE][`SRB_B_CMP_CHANGE] = 1'b1;
    end
    if (CMP_CHANGE_SET_IN[1]) begin
      next_bank[`SRB_I_CMP_TWO][`SRB_B_CMP_CHANGE] = 1'b1;
    end
  end

  // register storage, one byte of flip-flops per slot
  for (genvar s = 0; s < `SRB_NUM_REGS; s++) begin : g_slot
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
        bank[s] <= reset_value(s);
      end else if (CE_IN) begin
        bank[s] <= next_bank[s];
      end
    end
  end

  // software reset request is a one cycle pulse and is never stored
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      soft_reset <= 1'b0;
    end else if (CE_IN) begin
      soft_reset <= byte_wr
                    && wr_dec.slot == `SRB_I_AUX_FN
                    && WDATA_IN[`SRB_B_SOFT_RESET];
    end
  end

  // read data, registered; misses answer zero
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      RDATA_OUT <= 8'h00;
    end else if (CE_IN && RD_IN) begin
      RDATA_OUT <= read_view(rd_dec, bank[rd_dec.slot]);
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      BIT_DATA_OUT <= 1'b0;
    end else if (CE_IN && BIT_RD_IN) begin
      BIT_DATA_OUT <= bit_dec.hit
                      && bank[bit_dec.slot][BIT_ADDR_IN[2:0]];
    end
  end

  assign SOFT_RESET_OUT = soft_reset;
  assign DATA_POINTER_OUT = {bank[`SRB_I_DATA_POINTER_PAIR_HI],
                             bank[`SRB_I_DATA_POINTER_PAIR_LO]};
  assign CLOCK_DIVIDER_OUT = bank[`SRB_I_CLK_DIV];
  assign CONV_CONTROL_OUT = bank[`SRB_I_CONV_CTL];
  assign CONV_MODE_A_OUT = bank[`SRB_I_MODE_A];
  assign CONV_MODE_B_OUT = bank[`SRB_I_MODE_B];
  assign CONV_INPUT_SEL_OUT = bank[`SRB_I_IN_SEL];
  assign LOWER_BOUND_OUT = bank[`SRB_I_LO_BOUND];
  assign UPPER_BOUND_OUT = bank[`SRB_I_HI_BOUND];
  assign AUX_FUNCTION_OUT = bank[`SRB_I_AUX_FN];
  assign CMP_ONE_CONTROL_OUT = bank[`SRB_I_CMP_ONE];
  assign CMP_TWO_CONTROL_OUT = bank[`SRB_I_CMP_TWO];
  assign BAUD_CONTROL_OUT = bank[`SRB_I_BAUD_CTL][1:0];
  assign BAUD_DIVISOR_OUT = {bank[`SRB_I_BAUD_HI],
                             bank[`SRB_I_BAUD_LO]};
  assign FLASH_ADDRESS_OUT = {bank[`SRB_I_FLASH_HI],
                              bank[`SRB_I_FLASH_LO]};
  assign ACCUMULATOR_OUT = bank[`SRB_I_ACCUM];
  assign MULT_OPERAND_OUT = bank[`SRB_I_MULT_OP];

endmodule

// *** test/srb_bank_sva.sv ***
// assertions on the register bank ports
`timescale 1ns/1ps
module srb_bank_sva (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  // core access
  input wire logic CE_IN,
  input wire logic [7:0] ADDR_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic [7:0] RDATA_OUT,
  input wire logic [7:0] BIT_ADDR_IN,
  input wire logic BIT_WR_IN,
  input wire logic BIT_VAL_IN,
  // register contents
  input wire logic [7:0] UPPER_BOUND_OUT,
  input wire logic [7:0] ACCUMULATOR_OUT,
  input wire logic [7:0] AUX_FUNCTION_OUT,
  input wire logic SOFT_RESET_OUT
);
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_B_IN);
  a_bound_reset: assert property ($rose(RST_B_IN) |->
    UPPER_BOUND_OUT == 8'hFF) else $error("upper bound not all ones");
  a_accum_write: assert property (CE_IN && WR_IN && ADDR_IN == 8'hE0
    && !BIT_WR_IN |=> ACCUMULATOR_OUT == $past(WDATA_IN))
    else $error("accumulator write lost");
  a_bit_write: assert property (CE_IN && BIT_WR_IN
    && BIT_ADDR_IN[7:3] == 5'h1C |=>
    ACCUMULATOR_OUT[$past(BIT_ADDR_IN[2:0])] == $past(BIT_VAL_IN))
    else $error("accumulator bit write lost");
  a_baud_reserved: assert property (CE_IN && RD_IN
    && ADDR_IN == 8'hBD |=> RDATA_OUT[7:2] == 6'h00)
    else $error("baud control reserved bits not zero");
  a_fixed_zero: assert property (CE_IN && RD_IN
    && ADDR_IN == 8'hA2 |=> RDATA_OUT[3:2] == 2'h0)
    else $error("auxiliary fixed bits not zero");
  a_unmapped_read: assert property (CE_IN && RD_IN
    && ADDR_IN == 8'hA4 |=> RDATA_OUT == 8'h00)
    else $error("unmapped read not zero");
  a_soft_pulse: assert property (CE_IN && WR_IN && ADDR_IN == 8'hA2
    && WDATA_IN[3] |=> SOFT_RESET_OUT && !AUX_FUNCTION_OUT[3])
    else $error("soft reset pulse missing");
  a_read_hold: assert property (!(CE_IN && RD_IN) |=>
    $stable(RDATA_OUT)) else $error("read data moved without read");
endmodule

bind srb_bank srb_bank_sva i_srb_bank_sva (.CLK_IN, .RST_B_IN, .CE_IN,
  .ADDR_IN, .WR_IN, .RD_IN, .WDATA_IN, .RDATA_OUT, .BIT_ADDR_IN,
  .BIT_WR_IN, .BIT_VAL_IN, .UPPER_BOUND_OUT, .ACCUMULATOR_OUT,
  .AUX_FUNCTION_OUT, .SOFT_RESET_OUT);

// *** test/srb_core_model.sv ***
// core side model making byte and bit accesses
`timescale 1ns/1ps
module srb_core_model (
  // clock and answers
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  input wire logic bit_data_in,
  // access strobes
  output logic [7:0] addr_out,
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] wdata_out,
  output logic [7:0] bit_addr_out,
  output logic bit_wr_out,
  output logic bit_val_out,
  output logic bit_rd_out
);
  // rude: write reserved and fixed bits as given
  logic rude = 1'b0;
  initial begin
    {addr_out, wr_out, rd_out, wdata_out} = '0;
    {bit_addr_out, bit_wr_out, bit_val_out, bit_rd_out} = '0;
  end
  function automatic logic [7:0] mask(input logic [7:0] a);
    case (a)
      8'hA1: return 8'hEA;
      8'hA2: return 8'hF9;
      8'hA3, 8'hC0: return 8'hF0;
      8'hBD: return 8'h03;
      8'hAC, 8'hAD: return 8'h3F;
      default: return 8'hFF;
    endcase
  endfunction
  // b selects bit access, w selects write; q is the read answer
  task automatic go(input logic b, w, input logic [7:0] a, d,
                    output logic [7:0] q);
    @(posedge clk_in);
    addr_out <= a;
    bit_addr_out <= a;
    wdata_out <= (rude | b) ? d : d & mask(a);
    bit_val_out <= d[0];
    {bit_wr_out, bit_rd_out} <= {b & w, b & !w};
    {wr_out, rd_out} <= {!b & w, !b & !w};
    @(posedge clk_in);
    {bit_wr_out, bit_rd_out, wr_out, rd_out} <= 4'h0;
    @(posedge clk_in);
    q = b ? {7'h00, bit_data_in} : rdata_in;
  endtask
endmodule

// *** test/srb_bank_tb.sv ***
// self-checking bench for the register bank
`timescale 1ns/1ps
module srb_bank_tb;
  import srb_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic done = 1'b0;
  logic [3:0] ld = 4'h0;
  srb_byte_t rdin = 8'h00;
  logic [1:0] lvl = 2'h0;
  logic [1:0] chg = 2'h0;
  logic [7:0] addr, wdata, baddr, rdata, acc, mult, ctl;
  logic wr, rd, bwr, bval, brd, bdat;
  logic [15:0] data_pointer_pair, fla, baud;
  int error_cnt = 0;
  int num_checks = 0;
  logic [31:0] seed = 32'hc750_a770;
  logic [7:0] adr [23] = '{8'h82, 8'h83, 8'h95, 8'h97, 8'hA1, 8'hA2,
    8'hA3, 8'hAC, 8'hAD, 8'hBC, 8'hBD, 8'hBE, 8'hBF, 8'hC0, 8'hC4,
    8'hD5, 8'hD6, 8'hD7, 8'hE0, 8'hE6, 8'hE7, 8'hF0, 8'hF5};

  srb_bank i_srb_bank (.CLK_IN(clk), .RST_B_IN(rst_b), .CE_IN(ce),
    .ADDR_IN(addr), .WR_IN(wr), .RD_IN(rd), .WDATA_IN(wdata),
    .RDATA_OUT(rdata), .BIT_ADDR_IN(baddr), .BIT_WR_IN(bwr),
    .BIT_VAL_IN(bval), .BIT_RD_IN(brd), .BIT_DATA_OUT(bdat),
    .CONV_DONE_SET_IN(done), .RESULT_LOAD_IN(ld), .RESULT_DATA_IN(rdin),
    .CMP_LEVEL_IN(lvl), .CMP_CHANGE_SET_IN(chg), .DATA_POINTER_OUT(data_pointer_pair),
    .CLOCK_DIVIDER_OUT(), .CONV_CONTROL_OUT(ctl), .CONV_MODE_A_OUT(),
    .CONV_MODE_B_OUT(), .CONV_INPUT_SEL_OUT(), .LOWER_BOUND_OUT(),
    .UPPER_BOUND_OUT(), .AUX_FUNCTION_OUT(), .SOFT_RESET_OUT(),
    .CMP_ONE_CONTROL_OUT(), .CMP_TWO_CONTROL_OUT(), .BAUD_CONTROL_OUT(),
    .BAUD_DIVISOR_OUT(baud), .FLASH_ADDRESS_OUT(fla), .ACCUMULATOR_OUT(acc),
    .MULT_OPERAND_OUT(mult));
  srb_core_model i_srb_core_model (.clk_in(clk), .rdata_in(rdata),
    .bit_data_in(bdat), .addr_out(addr), .wr_out(wr), .rd_out(rd),
    .wdata_out(wdata), .bit_addr_out(baddr), .bit_wr_out(bwr),
    .bit_val_out(bval), .bit_rd_out(brd));

  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {1'b0, x[31:1]} ^ (x[0] ? 32'h8020_0003 : 32'h0000_0000);
  endfunction
  // bits that read back what was written
  function automatic logic [7:0] rmask(input logic [7:0] a);
    case (a)
      8'hA1: return 8'hEA;
      8'hA2: return 8'hF1;
      8'hA3, 8'hC0: return 8'hF0;
      8'hBD: return 8'h03;
      8'hAC, 8'hAD: return 8'h3D;
      default: return 8'hFF;
    endcase
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic g(input logic b, w, input logic [7:0] a, d,
                   output logic [7:0] q);
    i_srb_core_model.go(b, w, a, d, q);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    forever #2.5 clk = ~clk;
  end
  initial begin
    #200000;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    logic [7:0] d;
    logic [7:0] x;
    logic [7:0] ea;
    logic [7:0] em;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    foreach (adr[i]) begin
      g(0, 0, adr[i], 8'h00, d);
      chk(d, adr[i] == 8'hC4 ? 8'hFF : 8'h00);
    end
    $display("reset value test done");
    i_srb_core_model.rude = 1'b1;
    repeat (3) foreach (adr[i]) begin
      seed = nxt(seed);
      g(0, 1, adr[i], seed[7:0], x);
      g(0, 0, adr[i], 8'h00, d);
      chk(d, seed[7:0] & rmask(adr[i]));
    end
    g(0, 1, 8'hA4, 8'hFF, x);
    g(0, 0, 8'hA4, 8'h00, d);
    chk(d, 8'h00);
    g(0, 1, 8'h83, 8'hA5, x);
    g(0, 1, 8'h82, 8'h3C, x);
    chk(data_pointer_pair[15:8], 8'hA5);
    chk(data_pointer_pair[7:0], 8'h3C);
    g(0, 1, 8'hE7, 8'h5A, x);
    g(0, 1, 8'hBE, 8'hC3, x);
    chk(fla[15:8], 8'h5A);
    chk(baud[7:0], 8'hC3);
    g(0, 1, 8'hBC, 8'h11, x);
    ce <= 1'b0;
    g(0, 1, 8'hBC, 8'h77, x);
    ce <= 1'b1;
    g(0, 0, 8'hBC, 8'h00, d);
    chk(d, 8'h11);
    g(0, 1, 8'hA2, 8'h08, x);
    $display("byte access test done");
    i_srb_core_model.rude = 1'b0;
    g(0, 1, 8'hE0, 8'h00, x);
    g(0, 1, 8'hF0, 8'h00, x);
    ea = 8'h00;
    em = 8'h00;
    for (int n = 0; n < 8; n++) begin
      seed = nxt(seed);
      ea[n] = seed[0];
      em[n] = seed[1];
      g(1, 1, 8'hE0 + 8'(n), {7'h00, seed[0]}, x);
      g(1, 1, 8'hF0 + 8'(n), {7'h00, seed[1]}, x);
      g(1, 0, 8'hF0 + 8'(n), 8'h00, d);
      chk(d, {7'h00, seed[1]});
    end
    chk(acc, ea);
    chk(mult, em);
    $display("bit access test done");
    for (int c = 0; c < 4; c++) begin
      seed = nxt(seed);
      @(posedge clk);
      ld <= 4'h1 << c;
      rdin <= seed[7:0];
      @(posedge clk);
      ld <= 4'h0;
      g(0, 0, c < 3 ? 8'hD5 + 8'(c) : 8'hF5, 8'h00, d);
      chk(d, seed[7:0]);
    end
    g(0, 1, 8'h97, 8'h00, x);
    g(0, 1, 8'hAC, 8'h00, x);
    @(posedge clk);
    done <= 1'b1;
    lvl <= 2'h3;
    chg <= 2'h1;
    @(posedge clk);
    done <= 1'b0;
    chg <= 2'h0;
    g(0, 0, 8'hAC, 8'h00, d);
    chk(d & 8'h03, 8'h03);
    chk(ctl & 8'h08, 8'h08);
    $display("peripheral test done");
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    g(0, 0, 8'hC4, 8'h00, d);
    chk(d, 8'hFF);
    chk(acc, 8'h00);
    $display("second reset test done");
    report_and_stop();
  end
endmodule
